/* File: verilog/lfg_pkg.sv */
// Constants, gamma table and carrier types of the LED fade controller.
package lfg_pkg;

   // Clock and the time figures that the counters are derived from.
   localparam int unsigned LFG_CLK_HZ          = 50_000_000;
   localparam int unsigned LFG_CLK_PERIOD_NS   = 20;
   localparam int unsigned LFG_RAMP_NS_PER_OHM = 2500;
   localparam int unsigned LFG_INSTANT_US      = 70;
   localparam int unsigned LFG_SHORT_FILTER_MS = 5;
   localparam int unsigned LFG_PWM_HZ          = 220;

   // Cycle counts derived from the times above.
   localparam int unsigned LFG_CYC_PER_OHM =
      LFG_RAMP_NS_PER_OHM / LFG_CLK_PERIOD_NS;
   localparam int unsigned LFG_INSTANT_CYC =
      (LFG_INSTANT_US * 1000) / LFG_CLK_PERIOD_NS;
   localparam int unsigned LFG_SHORT_FILTER_CYC =
      (LFG_SHORT_FILTER_MS * 1_000_000) / LFG_CLK_PERIOD_NS;
   localparam int unsigned LFG_PWM_PERIOD_CYC = LFG_CLK_HZ / LFG_PWM_HZ;

   // Gamma table geometry and linear scale.
   localparam logic [5:0] LFG_LAST_IDX   = 6'h3E;
   localparam logic [9:0] LFG_FULL_SCALE = 10'h3E8;
   localparam int unsigned LFG_PWM_SLOTS = 1000;

   // Thermal rolloff in permille of the set current.
   localparam logic [13:0] LFG_ROLL_PER_C     = 14'h0026;
   localparam logic [13:0] LFG_ROLL_OFF_DROP  = 14'h03B6;

   // Register indices and reset values.
   localparam logic [3:0]  LFG_REG_UP_OHMS = 4'h0;
   localparam logic [3:0]  LFG_REG_DN_OHMS = 4'h1;
   localparam logic [3:0]  LFG_REG_STATUS  = 4'h2;
   localparam logic [19:0] LFG_OHMS_RST    = 20'h1_86A0;

   localparam logic [9:0] LFG_GAMMA [0:62] = '{
      10'd0,   10'd2,   10'd4,   10'd6,   10'd8,   10'd10,  10'd12,
      10'd16,  10'd20,  10'd24,  10'd28,  10'd32,  10'd36,  10'd42,
      10'd48,  10'd54,  10'd60,  10'd66,  10'd72,  10'd80,  10'd88,
      10'd96,  10'd104, 10'd112, 10'd120, 10'd130, 10'd140, 10'd150,
      10'd160, 10'd170, 10'd180, 10'd194, 10'd208, 10'd222, 10'd236,
      10'd250, 10'd264, 10'd282, 10'd300, 10'd318, 10'd336, 10'd354,
      10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482, 10'd504,
      10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
      10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000};

   // Fade sequencer states, Gray coded around the on/off cycle.
   typedef enum logic [1:0] {
      LFG_OFF  = 2'b00,
      LFG_UP   = 2'b01,
      LFG_ON   = 2'b11,
      LFG_DOWN = 2'b10
   } lfg_state_t;

   // Per channel fade status as seen by software.
   typedef struct packed {
      lfg_state_t state;
      logic [5:0] index;
   } lfg_fade_t;

   // Status word layout.
   typedef struct packed {
      logic [10:0] zero;
      logic        shutdown;
      logic [2:0]  short_fault;
      lfg_fade_t   ch1;
      lfg_fade_t   ch0;
      logic        fault_pin;
   } lfg_status_t;

endpackage : lfg_pkg

/* File: verilog/lfg_ctrl.sv */
// Two channel gamma fade sequencer with short and thermal supervision.
// Function
// - Ramp lasts 2.5 us per ohm
// - Zero setting gives 70 us ramp
// - Zero setting never bypasses switch debounce
// - 63 gamma levels, full scale 1000
// - Levels 0..15 as tabulated
// - Levels 16..31 as tabulated
// - Levels 32..47 as tabulated
// - Levels 48..62 as tabulated
// - Short declared after 5 ms low
// - Short cuts that channel, reports fault
// - Short gone restores current, releases report
// - Fault report is open drain
// - Rolloff 3.8 percent per degree, off below 5
// - Shutdown temperature turns off, reports fault
// - Ignore enables until cooled, then release
// - 220 Hz PWM follows gamma level
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns

module lfg_ctrl
   import lfg_pkg::*;
#(
   parameter int unsigned SHORT_FILTER_CYC = LFG_SHORT_FILTER_CYC,
   parameter int unsigned PWM_PERIOD_CYC   = LFG_PWM_PERIOD_CYC
) (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic [1:0]  channel_switch_i,
   input  wire logic [2:0]  short_detect_i,
   input  wire logic        over_temp_i,
   input  wire logic        shutdown_temp_i,
   input  wire logic [7:0]  temp_excess_i,
   input  wire logic        fault_report_n_i,
   output logic             fault_report_n_o,
   output logic             fault_report_n_oe_n_o,
   output logic      [1:0]  led_drive_o,
   output logic      [2:0]  reduced_current_o,
   output logic      [9:0]  current_scale_o,
   output logic             out_enable_o
);

   localparam int unsigned SLOT_CYC = PWM_PERIOD_CYC / LFG_PWM_SLOTS;

   logic        rst_sync1_reg;
   logic        rst_n_reg;
   logic [19:0] up_ohms_reg;
   logic [19:0] dn_ohms_reg;
   logic [31:0] rdata_reg;
   logic [17:0] slot_cnt_reg;
   logic [9:0]  phase_reg;
   logic        shutdown_reg;
   logic [9:0]  scale_reg;
   logic        roll_off_reg;
   logic [2:0]  short_fault;
   logic [2:0]  short_next;
   logic        shutdown_next;
   logic        roll_off_next;
   logic        report_oe_n_reg;
   logic        out_enable_reg;
   lfg_fade_t   fade [0:1];
   lfg_status_t status;

   // Reset is released through two flops so every register leaves
   // reset on the same edge.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync1_reg <= 1'b0;
         rst_n_reg     <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n_reg     <= rst_sync1_reg;
      end
   end

   // Fade resistor values in ohms; zero stands for a grounded pin.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         up_ohms_reg <= LFG_OHMS_RST;
         dn_ohms_reg <= LFG_OHMS_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == LFG_REG_UP_OHMS) begin
            up_ohms_reg <= reg_wdata_i[19:0];
         end
         if (reg_addr_i == LFG_REG_DN_OHMS) begin
            dn_ohms_reg <= reg_wdata_i[19:0];
         end
      end
   end

   // Status word; unused bits read as zero.
   always_comb begin
      status             = '0;
      status.shutdown    = shutdown_reg;
      status.short_fault = short_fault;
      status.ch1         = fade[1];
      status.ch0         = fade[0];
      status.fault_pin   = fault_report_n_i;
   end

   // Read data stand only in the cycle after the strobe, zero otherwise.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata_reg <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            LFG_REG_UP_OHMS: rdata_reg <= {12'h000, up_ohms_reg};
            LFG_REG_DN_OHMS: rdata_reg <= {12'h000, dn_ohms_reg};
            LFG_REG_STATUS:  rdata_reg <= status;
            default:         rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata_o = rdata_reg;

   // shared PWM timebase.
   // The period is split into 1000 slots so the duty compares directly
   // against the gamma level without a multiplier.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         slot_cnt_reg <= '0;
         phase_reg    <= '0;
      end else if (slot_cnt_reg == 18'(SLOT_CYC - 1)) begin
         slot_cnt_reg <= '0;
         if (phase_reg == 10'(LFG_PWM_SLOTS - 1)) begin
            phase_reg <= '0;
         end else begin
            phase_reg <= phase_reg + 10'h001;
         end
      end else begin
         slot_cnt_reg <= slot_cnt_reg + 18'h0_0001;
      end
   end

   // cleared only by the cooled indication; a new trip wins.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         shutdown_reg <= 1'b0;
      end else if (shutdown_temp_i) begin
         shutdown_reg <= 1'b1;
      end else if (!over_temp_i) begin
         shutdown_reg <= 1'b0;
      end
   end

   // linear rolloff.
   // Cut is 38 permille per degree; past 950 the current would be
   // under 5 percent, so the outputs are switched off instead.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         scale_reg    <= LFG_FULL_SCALE;
         roll_off_reg <= 1'b0;
      end else if (!over_temp_i) begin
         scale_reg    <= LFG_FULL_SCALE;
         roll_off_reg <= 1'b0;
      end else if (14'(temp_excess_i) * LFG_ROLL_PER_C >
                   LFG_ROLL_OFF_DROP) begin
         scale_reg    <= '0;
         roll_off_reg <= 1'b1;
      end else begin
         scale_reg    <= 10'(14'(LFG_FULL_SCALE) -
                             14'(temp_excess_i) * LFG_ROLL_PER_C);
         roll_off_reg <= 1'b0;
      end
   end

   assign current_scale_o = scale_reg;

   // Next values of the two thermal states, so the flops below move on
   // the same edge as the states and add no cycle of lag.
   assign shutdown_next = shutdown_temp_i || (shutdown_reg && over_temp_i);
   assign roll_off_next = over_temp_i &&
                          (14'(temp_excess_i) * LFG_ROLL_PER_C >
                           LFG_ROLL_OFF_DROP);

   // outputs off in shutdown or deep rolloff.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         out_enable_reg <= 1'b1;
      end else begin
         out_enable_reg <= !shutdown_next && !roll_off_next;
      end
   end

   assign out_enable_o = out_enable_reg;

   // Short filters for all three outputs.
   for (genvar s = 0; s < 3; s++) begin : g_short
      logic [17:0] cnt_reg;
      logic        fault_reg;

      // any gap restarts the filter and clears the fault.
      always_ff @(posedge clock_i or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            cnt_reg <= '0;
         end else if (!short_detect_i[s]) begin
            cnt_reg <= '0;
         end else if (cnt_reg != 18'(SHORT_FILTER_CYC)) begin
            cnt_reg <= cnt_reg + 18'h0_0001;
         end
      end

      // only the shorted output drops to reduced current.
      // The flag is fed from the counter's next value, so it rises on
      // the very edge at which the count reaches the filter length.
      assign short_next[s] = short_detect_i[s] &&
                             (cnt_reg >= 18'(SHORT_FILTER_CYC - 1));

      always_ff @(posedge clock_i or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            fault_reg <= 1'b0;
         end else begin
            fault_reg <= short_next[s];
         end
      end

      assign short_fault[s] = fault_reg;
   end

   assign reduced_current_o = short_fault;

   // open drain: driven low only while a fault stands.
   // the report releases as soon as the die has cooled.
   // The enable is a flop so that two causes changing on one edge can
   // never leave a glitch on the shared, pulled up fault line.
   always_ff @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         report_oe_n_reg <= 1'b1;
      end else begin
         report_oe_n_reg <= !(|short_next || shutdown_next);
      end
   end

   assign fault_report_n_o      = 1'b0;
   assign fault_report_n_oe_n_o = report_oe_n_reg;

   // Fade sequencers for the two main channels.
   for (genvar c = 0; c < 2; c++) begin : g_fade
      lfg_state_t  state_reg;
      logic [5:0]  idx_reg;
      logic [26:0] acc_reg;
      logic [26:0] thr;
      logic [26:0] acc_sum;
      logic        step;
      logic        toggle;
      logic        drive_reg;

      // step threshold from the resistor of the active direction.
      // a zero setting falls back to the short instant ramp.
      // adding 62 per cycle against the full ramp length spreads
      // the 62 steps evenly with no division and no drift.
      always_comb begin
         thr = '0;
         if (state_reg == LFG_DOWN) begin
            if (dn_ohms_reg == '0) begin
               thr = 27'(LFG_INSTANT_CYC);
            end else begin
               thr = 27'(dn_ohms_reg) * 27'(LFG_CYC_PER_OHM);
            end
         end else if (up_ohms_reg == '0) begin
            thr = 27'(LFG_INSTANT_CYC);
         end else begin
            thr = 27'(up_ohms_reg) * 27'(LFG_CYC_PER_OHM);
         end
      end

      assign acc_sum = acc_reg + 27'(LFG_LAST_IDX);
      assign step    = (acc_sum >= thr);
      // the debounced request takes the same path in every setting.
      // requests are dropped while shut down.
      assign toggle  = channel_switch_i[c] && !shutdown_reg;

      // Step interval accumulator, restarted on every change of direction.
      always_ff @(posedge clock_i or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            acc_reg <= '0;
         end else if (toggle || shutdown_reg) begin
            acc_reg <= '0;
         end else if (state_reg == LFG_UP || state_reg == LFG_DOWN) begin
            if (step) begin
               acc_reg <= acc_sum - thr;
            end else begin
               acc_reg <= acc_sum;
            end
         end
      end

      // Sequencer state and gamma index.
      always_ff @(posedge clock_i or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            state_reg <= LFG_OFF;
            idx_reg   <= '0;
         end else if (shutdown_reg) begin
            state_reg <= LFG_OFF;
            idx_reg   <= '0;
         end else if (toggle) begin
            // an interrupted ramp reverses from the current index.
            case (state_reg)
               LFG_OFF:  state_reg <= LFG_UP;
               LFG_UP:   state_reg <= LFG_DOWN;
               LFG_ON:   state_reg <= LFG_DOWN;
               LFG_DOWN: state_reg <= LFG_UP;
               default:  state_reg <= LFG_OFF;
            endcase
         end else begin
            case (state_reg)
               LFG_UP: begin
                  if (idx_reg == LFG_LAST_IDX) begin
                     state_reg <= LFG_ON;
                  end else if (step) begin
                     idx_reg <= idx_reg + 6'h01;
                  end
               end
               LFG_DOWN: begin
                  if (idx_reg == 6'h00) begin
                     state_reg <= LFG_OFF;
                  end else if (step) begin
                     idx_reg <= idx_reg - 6'h01;
                  end
               end
               LFG_ON:  idx_reg <= LFG_LAST_IDX;
               LFG_OFF: idx_reg <= 6'h00;
               default: state_reg <= LFG_OFF;
            endcase
         end
      end

      // duty from the gamma level against the 1000-slot phase.
      // levels 0 to 15 from the table.
      // levels 16 to 31 from the table.
      // levels 32 to 47 from the table.
      // levels 48 to 62 from the table.
      // Level 1000 beats every phase, so full brightness is steady on.
      always_ff @(posedge clock_i or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            drive_reg <= 1'b0;
         end else begin
            drive_reg <= (LFG_GAMMA[idx_reg] > phase_reg) &&
                         (state_reg != LFG_OFF) &&
                         !shutdown_reg && !roll_off_reg;
         end
      end

      assign led_drive_o[c]  = drive_reg;
      assign fade[c].state   = state_reg;
      assign fade[c].index   = idx_reg;
   end

endmodule : lfg_ctrl

/* File: verification/lfg_ctrl_assertions.sv */
// Port level assertions of the LED fade controller.
`timescale 1ns/1ns
module lfg_ctrl_assertions
   import lfg_pkg::*;
#(
   parameter int unsigned SHORT_FILTER_CYC = LFG_SHORT_FILTER_CYC
) (
   input wire logic       clock_i,
   input wire logic       nrst_i,
   input wire logic [2:0] short_detect_i,
   input wire logic       over_temp_i,
   input wire logic       shutdown_temp_i,
   input wire logic [7:0] temp_excess_i,
   input wire logic       fault_report_n_o,
   input wire logic       fault_report_n_oe_n_o,
   input wire logic [1:0] led_drive_o,
   input wire logic [2:0] reduced_current_o,
   input wire logic [9:0] current_scale_o,
   input wire logic       out_enable_o
);
   logic [1:0]  live_reg;
   logic [31:0] run_reg;
   // Mirror the two flop release so no check fires inside that window.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         live_reg <= 2'h0;
      end else begin
         live_reg <= {live_reg[0], 1'b1};
      end
   end
   // Consecutive low voltage samples seen on the first output.
   always_ff @(posedge clock_i) begin
      if (!live_reg[1] || !short_detect_i[0]) begin
         run_reg <= 32'h0;
      end else begin
         run_reg <= run_reg + 32'h1;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!live_reg[1]);
   // Die held above the shutdown point for three samples.
   sequence s_hot_hold;
      shutdown_temp_i [*3];
   endsequence
   a_short_filter: assert property (
      $rose(reduced_current_o[0]) |-> run_reg + 32'h1 >= SHORT_FILTER_CYC
      && run_reg <= SHORT_FILTER_CYC + 2) else $error("short cut mistimed");
   a_short_clears: assert property (
      !short_detect_i[0] |=> !reduced_current_o[0])
      else $error("reduced current stuck");
   a_short_reports: assert property (
      |reduced_current_o |-> !fault_report_n_oe_n_o)
      else $error("short not reported");
   a_fault_drain: assert property (
      !fault_report_n_oe_n_o |-> fault_report_n_o == 1'b0)
      else $error("fault line driven high");
   a_fault_release: assert property (
      !over_temp_i && !shutdown_temp_i && !(|short_detect_i)
      |=> fault_report_n_oe_n_o) else $error("fault line not released");
   a_roll_scale: assert property (
      over_temp_i && temp_excess_i <= 8'd25 |=> current_scale_o ==
      10'(16'd1000 - 16'd38 * $past(temp_excess_i)))
      else $error("rolloff scale wrong");
   a_roll_cutoff: assert property (
      over_temp_i && temp_excess_i > 8'd25 |=> !out_enable_o)
      else $error("rolloff cutoff missing");
   a_cool_scale: assert property (
      !over_temp_i |=> current_scale_o == 10'h3E8)
      else $error("scale reduced while cool");
   a_hot_shutdown: assert property (
      shutdown_temp_i |=> !out_enable_o && !fault_report_n_oe_n_o)
      else $error("shutdown not applied");
   a_hot_dark: assert property (
      s_hot_hold |-> led_drive_o == 2'b00) else $error("drive on while hot");
endmodule : lfg_ctrl_assertions

/* File: verification/lfg_far_end.sv */
// Far side model: LED string short indications and the pulled up fault line.
`timescale 1ns/1ns
module lfg_far_end (
   input  wire logic [2:0] short_cmd_i,
   input  wire logic       fault_oe_n_i,
   output logic      [2:0] short_detect_o,
   output logic            fault_line_o
);
   // pulled up line
   // The board resistor lifts the line whenever the driver lets go.
   assign fault_line_o = fault_oe_n_i ? 1'b1 : 1'b0;
   // steady low voltage
   // A shorted string stays below threshold until the short is removed.
   assign short_detect_o = short_cmd_i;
endmodule : lfg_far_end

/* File: verification/lfg_ctrl_test.sv */
// Self-checking bench for the LED fade controller.
`timescale 1ns/1ns
`define LFG_CHECK(nm, exp, got) begin num_checks++; \
   if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module lfg_ctrl_test
   import lfg_pkg::*;
;
   localparam int unsigned SF = 20;
   localparam int unsigned PP = 2000;
   logic        clock_i = 1'b0;
   logic        nrst_i  = 1'b0;
   logic [3:0]  addr    = 4'h0;
   logic [31:0] wdata   = 32'h0;
   logic        wr_s    = 1'b0;
   logic        rd_s    = 1'b0;
   logic [1:0]  sw      = 2'h0;
   logic [2:0]  scmd    = 3'h0;
   logic        ot      = 1'b0;
   logic        sd      = 1'b0;
   logic [7:0]  ex      = 8'h0;
   logic [31:0] rdata, d;
   logic [2:0]  sdet, red;
   logic [1:0]  drv;
   logic [9:0]  scale;
   logic        fpin, fo, foe, oen;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n, h, h2, i1;
   lfg_ctrl #(.SHORT_FILTER_CYC(SF), .PWM_PERIOD_CYC(PP)) dut_u (
      .clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
      .reg_rdata_o(rdata), .channel_switch_i(sw), .short_detect_i(sdet),
      .over_temp_i(ot), .shutdown_temp_i(sd), .temp_excess_i(ex),
      .fault_report_n_i(fpin), .fault_report_n_o(fo),
      .fault_report_n_oe_n_o(foe), .led_drive_o(drv),
      .reduced_current_o(red), .current_scale_o(scale), .out_enable_o(oen));
   lfg_far_end far_u (.short_cmd_i(scmd), .fault_oe_n_i(foe),
      .short_detect_o(sdet), .fault_line_o(fpin));
   // Free running 50 MHz clock.
   always #10 clock_i = ~clock_i;
   task automatic complete_run();
      if (n_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clock_i);
      wr_s <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clock_i);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   task automatic tog(input int c);
      sw[c] <= 1'b1;
      @(posedge clock_i);
      sw <= 2'h0;
      #1;
   endtask : tog
   // Poll status until a channel reaches a state, counting cycles.
   task automatic wait_st(input int c, input logic [1:0] st, output int k);
      k = 0;
      do begin
         rd(4'h2, d);
         k++;
      end while (d[8 * c + 8 -: 2] !== st && k < 12000);
   endtask : wait_st
   // High cycles of both drives over a whole PWM period.
   task automatic hi(output int k0, output int k1);
      k0 = 0;
      k1 = 0;
      repeat (PP) begin
         @(posedge clock_i);
         #1;
         k0 += drv[0];
         k1 += drv[1];
      end
   endtask : hi
   // Slow ramp holds each level longer than a PWM period.
   task automatic duty(input int k, input int g, input int g0);
      int t;
      t = 0;
      do begin
         rd(4'h2, d);
         t++;
      end while (d[14:9] !== 6'(k) && t < 20000);
      hi(h2, h);
      `LFG_CHECK("duty", 1'b1, h >= 2 * g - 4 && h <= 2 * g + 4)
      `LFG_CHECK("duty0", 1'b1, h2 >= 2 * g0 - 4 && h2 <= 2 * g0 + 4)
   endtask : duty
   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (70000) @(posedge clock_i);
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      #1;
      rd(4'h0, d);
      `LFG_CHECK("up_ohms", 32'h0001_86A0, d)
      // The bench shortens the ramps; the default stays a board value.
      `LFG_CHECK("board", 1'b1, d >= 32'h0001_86A0 && d <= 32'h0009_27C0)
      rd(4'h5, d);
      `LFG_CHECK("unmapped", 32'h0, d)
      wr(4'h0, 32'h0);
      tog(0);
      rd(4'h2, d);
      `LFG_CHECK("zero_set", LFG_UP, d[8:7])
      wait_st(0, LFG_ON, n);
      `LFG_CHECK("instant", 1'b1, n > 3400 && n < 3600)
      hi(h, h2);
      `LFG_CHECK("full", PP, h)
      // Forty ohms gives 80 cycles a step; reverse the ramp midway.
      wr(4'h0, 32'h28);
      wr(4'h1, 32'h28);
      tog(0);
      repeat (1500) @(posedge clock_i);
      #1;
      rd(4'h2, d);
      i1 = d[6:1];
      `LFG_CHECK("down", LFG_DOWN, d[8:7])
      `LFG_CHECK("idx", 1'b1, i1 > 40 && i1 < 46)
      tog(0);
      rd(4'h2, d);
      `LFG_CHECK("rev", LFG_UP, d[8:7])
      `LFG_CHECK("keep", 1'b1, (d[6:1] + 2 - i1) inside {[1:3]})
      wait_st(0, LFG_ON, n);
      `LFG_CHECK("rest", 1'b1, n + 150 > (62 - i1) * 80)
      `LFG_CHECK("rest", 1'b1, n < (62 - i1) * 80 + 150)
      // Channel 1 fades up while channel 0 fades down from full.
      wr(4'h0, 32'h3E8);
      wr(4'h1, 32'h3E8);
      tog(1);
      tog(0);
      duty(1, 2, 956);
      duty(7, 16, 722);
      duty(13, 42, 534);
      // channel 0 at index 45 checks a mid table level.
      duty(17, 66, 438);
      wr(4'h1, 32'h0);
      tog(1);
      wait_st(1, LFG_OFF, n);
      `LFG_CHECK("off", LFG_OFF, d[16:15])
      for (int s = 0; s < 3; s++) begin
         scmd[s] <= 1'b1;
         repeat (SF - 2) @(posedge clock_i);
         #1;
         `LFG_CHECK("early", 1'b0, red[s])
         repeat (5) @(posedge clock_i);
         #1;
         `LFG_CHECK("cut", 1'b1, red[s])
         rd(4'h2, d);
         `LFG_CHECK("pin", 1'b0, d[0])
         scmd <= 3'h0;
         repeat (2) @(posedge clock_i);
         #1;
         `LFG_CHECK("back", 1'b0, red[s])
         `LFG_CHECK("release", 1'b1, foe)
      end
      ot <= 1'b1;
      ex <= 8'h0A;
      repeat (3) @(posedge clock_i);
      #1;
      `LFG_CHECK("scale", 10'h26C, scale)
      ex <= 8'h1A;
      repeat (3) @(posedge clock_i);
      #1;
      `LFG_CHECK("rolloff", 1'b0, oen)
      sd <= 1'b1;
      repeat (3) @(posedge clock_i);
      #1;
      `LFG_CHECK("hot", 1'b0, foe)
      tog(0);
      rd(4'h2, d);
      `LFG_CHECK("ignored", LFG_OFF, d[8:7])
      sd <= 1'b0;
      ex <= 8'h0;
      repeat (3) @(posedge clock_i);
      #1;
      `LFG_CHECK("warm", 1'b0, foe)
      ot <= 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      `LFG_CHECK("cooled", 1'b1, foe)
      complete_run();
   end
endmodule : lfg_ctrl_test
bind lfg_ctrl lfg_ctrl_assertions #(.SHORT_FILTER_CYC(SHORT_FILTER_CYC)) chk_u (
   .clock_i(clock_i), .nrst_i(nrst_i), .short_detect_i(short_detect_i),
   .over_temp_i(over_temp_i), .shutdown_temp_i(shutdown_temp_i),
   .temp_excess_i(temp_excess_i), .fault_report_n_o(fault_report_n_o),
   .fault_report_n_oe_n_o(fault_report_n_oe_n_o), .led_drive_o(led_drive_o),
   .reduced_current_o(reduced_current_o), .current_scale_o(current_scale_o),
   .out_enable_o(out_enable_o));
